/* rtl/osc_ctrl.sv */
// Oscillator select, divider and tuning registers
// Assumes switch completion and lock events come from the analog clock unit
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
module osc_ctrl
  import osc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic unlocked,
  // Configuration
  input wire logic [2:0] config_source,
  input wire logic [1:0] switch_monitor_config,
  input wire logic switch_enabled,
  // Clock unit status
  input wire logic pll_locked,
  input wire logic monitor_fail,
  input wire logic new_clock_tick,
  input wire logic interrupt,
  // Controls
  output logic [2:0] current_source,
  output logic [2:0] requested_source,
  output logic pin_select_lock,
  output logic secondary_osc_enable,
  output logic switch_busy,
  output logic reduction_active,
  output logic [2:0] processor_clock_reduction,
  output logic [2:0] fast_rc_postscaler,
  output logic [1:0] pll_postscaler,
  output logic [4:0] pll_prescaler,
  output logic [8:0] pll_feedback_multiplier,
  output logic [5:0] fast_rc_trim
);
  logic [2:0] cur_r, req_r, doze_r, frcdiv_r;
  logic swlock_r, pinlock_r, fail_r, secen_r, swreq_r, roi_r, reduction_enable_r, strap_r;
  logic [1:0] post_r;
  logic [4:0] pre_r;
  logic [8:0] fbd_r;
  logic [5:0] tun_r;
  logic [3:0] wait_r;
  logic [15:0] rdata_r;
  logic wr_osc, wr_div, locked_sw, pll_locked_ok;

  assign wr_osc = wr && addr == ADDR_OSC_CONTROL && unlocked;
  assign wr_div = wr && addr == ADDR_CLOCK_DIVISOR;
  assign locked_sw = swlock_r && switch_monitor_config == MONITOR_SW_ONLY;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_r <= 1'b1;
    end else begin
      strap_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_r <= 3'h0;
    end else if (strap_r) begin
      req_r <= config_source;
    end else if (wr_osc) begin
      req_r <= wdata[REQ_POS +: 3];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur_r <= 3'h0;
    end else if (strap_r || !switch_enabled) begin
      cur_r <= config_source;
    end else if (swreq_r && wait_r == SWITCH_WAIT && new_clock_tick) begin
      cur_r <= req_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch request and wait counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      swreq_r <= 1'b0;
    end else if (!switch_enabled) begin
      swreq_r <= 1'b0;
    end else if (swreq_r) begin
      if (req_r == cur_r) begin
        swreq_r <= 1'b0;
      end else if (wait_r == SWITCH_WAIT && new_clock_tick) begin
        swreq_r <= 1'b0;
      end
    end else if (wr_osc && wdata[SWREQ_POS] && !locked_sw) begin
      swreq_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_r <= 4'h0;
    end else if (!swreq_r || req_r == cur_r) begin
      wait_r <= 4'h0;
    end else if (new_clock_tick && pll_locked_ok && wait_r != SWITCH_WAIT) begin
      wait_r <= wait_r + 4'h1;
    end
  end

  assign pll_locked_ok = (req_r != SRC_FRC_PLL && req_r != SRC_PRI_PLL) || pll_locked;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits of the oscillator register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      swlock_r <= 1'b0;
      pinlock_r <= 1'b0;
      secen_r <= 1'b0;
    end else if (wr_osc) begin
      swlock_r <= wdata[SWLOCK_POS];
      pinlock_r <= wdata[PINLOCK_POS];
      secen_r <= wdata[SECEN_POS];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fail_r <= 1'b0;
    end else if (monitor_fail) begin
      fail_r <= 1'b1;
    end else if (swreq_r && req_r != cur_r && wait_r == 4'h0) begin
      fail_r <= 1'b0;
    end else if (wr_osc && !wdata[FAIL_POS]) begin
      fail_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divisor, feedback and tuning registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      roi_r <= 1'b0;
      doze_r <= DOZE_RESET;
      frcdiv_r <= FRCDIV_RESET;
      post_r <= POST_RESET;
      pre_r <= PRE_RESET;
    end else if (wr_div) begin
      roi_r <= wdata[ROI_POS];
      doze_r <= wdata[DOZE_POS +: 3];
      frcdiv_r <= wdata[FRCDIV_POS +: 3];
      post_r <= wdata[POST_POS +: 2];
      pre_r <= wdata[PRE_POS +: 5];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reduction_enable_r <= 1'b0;
    end else if (interrupt && roi_r) begin
      reduction_enable_r <= 1'b0;
    end else if (wr_div) begin
      reduction_enable_r <= wdata[REDUCTION_ENABLE_POS];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fbd_r <= FBD_RESET;
    end else if (wr && addr == ADDR_PLL_FEEDBACK) begin
      fbd_r <= wdata[8:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tun_r <= TUN_RESET;
    end else if (wr && addr == ADDR_FRC_TUNING) begin
      tun_r <= wdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, unimplemented bits zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        ADDR_OSC_CONTROL: rdata_r <= {1'b0, cur_r, 1'b0, req_r, swlock_r, pinlock_r,
          pll_locked, 1'b0, fail_r, 1'b0, secen_r, swreq_r};
        ADDR_CLOCK_DIVISOR: rdata_r <= {roi_r, doze_r, reduction_enable_r, frcdiv_r, post_r, 1'b0,
          pre_r};
        ADDR_PLL_FEEDBACK: rdata_r <= {7'h00, fbd_r};
        ADDR_FRC_TUNING: rdata_r <= {10'h000, tun_r};
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata = rdata_r;
  assign current_source = cur_r;
  assign requested_source = req_r;
  assign pin_select_lock = pinlock_r;
  assign secondary_osc_enable = secen_r;
  assign switch_busy = swreq_r;
  assign reduction_active = reduction_enable_r;
  assign processor_clock_reduction = doze_r;
  assign fast_rc_postscaler = frcdiv_r;
  assign pll_postscaler = post_r;
  assign pll_prescaler = pre_r;
  assign pll_feedback_multiplier = fbd_r;
  assign fast_rc_trim = tun_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence req_taken_s;
    wr_osc && wdata[SWREQ_POS] && !locked_sw && switch_enabled && !swreq_r && !strap_r;
  endsequence

  req_set_a: assert property (@(posedge clk) disable iff (reset)
    req_taken_s |=> swreq_r) else $error("switch request not set");
  lock_block_a: assert property (@(posedge clk) disable iff (reset)
    !swreq_r && locked_sw && !strap_r |=> !swreq_r) else $error("locked switch started");
  sw_off_a: assert property (@(posedge clk) disable iff (reset)
    !switch_enabled |=> !swreq_r) else $error("request while disabled");
  redundant_a: assert property (@(posedge clk) disable iff (reset)
    swreq_r && req_r == cur_r && switch_enabled |=> !swreq_r) else $error("redundant kept");
  pll_wait_a: assert property (@(posedge clk) disable iff (reset)
    swreq_r && !pll_locked_ok |=> $stable(wait_r))
    else $error("wait advanced without lock");
  done_copy_a: assert property (@(posedge clk) disable iff (reset)
    $fell(swreq_r) && switch_enabled && !strap_r |-> cur_r == $past(req_r))
    else $error("source not copied");
  fail_sticky_a: assert property (@(posedge clk) disable iff (reset)
    monitor_fail |=> fail_r) else $error("fail flag not set");
  fail_hold_a: assert property (@(posedge clk) disable iff (reset)
    fail_r && !wr_osc && !swreq_r |=> fail_r) else $error("fail flag lost");
  roi_clear_a: assert property (@(posedge clk) disable iff (reset)
    interrupt && roi_r |=> !reduction_enable_r) else $error("reduction not cleared");
  unlock_a: assert property (@(posedge clk) disable iff (reset)
    wr && !unlocked && !strap_r |=> $stable(req_r)) else $error("locked write taken");

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequence steps
  sequence switch_pending_s;
    swreq_r && switch_enabled && req_r != cur_r;
  endsequence

  sequence switch_ready_s;
    swreq_r && switch_enabled && req_r != cur_r && wait_r == SWITCH_WAIT && new_clock_tick;
  endsequence

  strap_load_a: assert property (@(posedge clk) disable iff (reset)
    strap_r
    |=> req_r == $past(config_source) && !strap_r)
    else $error("configured source not loaded");

  osc_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_osc && !strap_r
    |=> req_r == $past(wdata[REQ_POS +: 3]))
    else $error("requested source not written");

  pin_lock_a: assert property (@(posedge clk) disable iff (reset)
    wr_osc
    |=> pinlock_r == $past(wdata[PINLOCK_POS]))
    else $error("pin select lock not written");

  sec_enable_a: assert property (@(posedge clk) disable iff (reset)
    wr_osc
    |=> secen_r == $past(wdata[SECEN_POS]))
    else $error("secondary enable not written");

  cur_hold_a: assert property (@(posedge clk) disable iff (reset)
    !strap_r && switch_enabled && !(swreq_r && wait_r == SWITCH_WAIT && new_clock_tick)
    |=> $stable(cur_r))
    else $error("current source moved");

  disabled_copy_a: assert property (@(posedge clk) disable iff (reset)
    !switch_enabled
    |=> cur_r == $past(config_source))
    else $error("current source not configured");

  wait_limit_a: assert property (@(posedge clk) disable iff (reset)
    1'b1
    |-> wait_r <= SWITCH_WAIT)
    else $error("wait counter overran");

  wait_step_a: assert property (@(posedge clk) disable iff (reset)
    switch_pending_s ##0 new_clock_tick && pll_locked_ok && wait_r != SWITCH_WAIT
    |=> wait_r == $past(wait_r) + 4'h1)
    else $error("wait counter missed a tick");

  wait_idle_a: assert property (@(posedge clk) disable iff (reset)
    !swreq_r
    |=> wait_r == 4'h0)
    else $error("wait counter not cleared");

  early_hold_a: assert property (@(posedge clk) disable iff (reset)
    switch_pending_s ##0 wait_r != SWITCH_WAIT
    |=> swreq_r)
    else $error("switch ended early");

  switch_done_a: assert property (@(posedge clk) disable iff (reset)
    switch_ready_s
    |=> !swreq_r && cur_r == $past(req_r))
    else $error("switch not completed");

  ////////////////////////////////////////////////////////////////////////////
  // Fail flag
  fail_clear_a: assert property (@(posedge clk) disable iff (reset)
    fail_r && !monitor_fail && wr_osc && !wdata[FAIL_POS]
    |=> !fail_r)
    else $error("fail flag not cleared");

  fail_one_a: assert property (@(posedge clk) disable iff (reset)
    fail_r && !monitor_fail && wr_osc && wdata[FAIL_POS] && !swreq_r
    |=> fail_r)
    else $error("fail flag cleared by one");

  fail_start_a: assert property (@(posedge clk) disable iff (reset)
    swreq_r && req_r != cur_r && wait_r == 4'h0 && !monitor_fail
    |=> !fail_r)
    else $error("fail flag kept at switch start");

  ////////////////////////////////////////////////////////////////////////////
  // Divisor and tuning registers
  div_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_div
    |=> doze_r == $past(wdata[DOZE_POS +: 3]) && frcdiv_r == $past(wdata[FRCDIV_POS +: 3])
      && post_r == $past(wdata[POST_POS +: 2]) && pre_r == $past(wdata[PRE_POS +: 5]))
    else $error("divisor not written");

  roi_keep_a: assert property (@(posedge clk) disable iff (reset)
    interrupt && !roi_r && !wr_div
    |=> $stable(reduction_enable_r))
    else $error("reduction changed by interrupt");

  fbd_write_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == ADDR_PLL_FEEDBACK
    |=> fbd_r == $past(wdata[8:0]))
    else $error("feedback not written");

  tun_write_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == ADDR_FRC_TUNING
    |=> tun_r == $past(wdata[5:0]))
    else $error("tuning not written");

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  rd_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rd
    |=> rdata_r == 16'h0000)
    else $error("read data not idle");

  rd_osc_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == ADDR_OSC_CONTROL
    |=> rdata_r[PLLLOCK_POS] == $past(pll_locked) && rdata_r[CUR_POS +: 3] == $past(cur_r))
    else $error("status read wrong");

  rd_osc_pad_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == ADDR_OSC_CONTROL
    |=> !rdata_r[15] && !rdata_r[11] && !rdata_r[4] && !rdata_r[2])
    else $error("control pad bit set");

  rd_div_pad_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == ADDR_CLOCK_DIVISOR
    |=> !rdata_r[5])
    else $error("divisor pad bit set");

  rd_fbd_pad_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == ADDR_PLL_FEEDBACK
    |=> rdata_r[15:9] == 7'h00)
    else $error("feedback pad bits set");

  rd_tun_pad_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == ADDR_FRC_TUNING
    |=> rdata_r[15:6] == 10'h000)
    else $error("tuning pad bits set");
endmodule // osc_ctrl

/* rtl/osc_ctrl_pkg.sv */
// Constants for the oscillator select and clock divider register block
// Assumes a 16-bit register port with one-cycle read latency
// Functional notes
// - current source field is read-only, eight codes
// - requested source field writable in bits 10-8
// - requested source loads from configuration on the first clock after reset release
// - switch lock blocks source change when enabled
// - pin select lock gates pin select writes
// - PLL lock bit mirrors lock or timer
// - clock fail bit set on monitor failure
// - secondary enable bit drives secondary oscillator
// - switch request cleared when switch completes
// - control register writes need prior unlock
// - interrupt clears reduction enable when recovering
// - reduction field divides by two to the code
// - reduction ratio applies only when enabled
// - fast RC postscaler codes, 111 divides 256
// - PLL postscaler 2,4,reserved,8; reset is 4
// - PLL prescaler is field plus two
// - PLL multiplier is field plus two, reset 50
// - six-bit signed trim shifts fast RC
// - instruction clock is oscillator divided by two
// - redundant switch request is cleared and aborted
// - switch waits ten new-clock cycles then copies
// - switching disabled holds request bit at zero
package osc_ctrl_pkg;
  localparam logic [1:0] ADDR_OSC_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CLOCK_DIVISOR = 2'h1;
  localparam logic [1:0] ADDR_PLL_FEEDBACK = 2'h2;
  localparam logic [1:0] ADDR_FRC_TUNING = 2'h3;
  localparam int CUR_POS = 12;
  localparam int REQ_POS = 8;
  localparam int SWLOCK_POS = 7;
  localparam int PINLOCK_POS = 6;
  localparam int PLLLOCK_POS = 5;
  localparam int FAIL_POS = 3;
  localparam int SECEN_POS = 1;
  localparam int SWREQ_POS = 0;
  localparam int ROI_POS = 15;
  localparam int DOZE_POS = 12;
  localparam int REDUCTION_ENABLE_POS = 11;
  localparam int FRCDIV_POS = 8;
  localparam int POST_POS = 6;
  localparam int PRE_POS = 0;
  localparam logic [2:0] DOZE_RESET = 3'h3;
  localparam logic [2:0] FRCDIV_RESET = 3'h0;
  localparam logic [1:0] POST_RESET = 2'h1;
  localparam logic [4:0] PRE_RESET = 5'h00;
  localparam logic [8:0] FBD_RESET = 9'h030;
  localparam logic [5:0] TUN_RESET = 6'h00;
  localparam logic [3:0] SWITCH_WAIT = 4'hA;
  localparam logic [1:0] MONITOR_SW_ONLY = 2'h1;
  typedef enum logic [2:0] {
    SRC_FRC = 3'b000, SRC_FRC_PLL = 3'b001, SRC_PRI = 3'b010, SRC_PRI_PLL = 3'b011,
    SRC_SEC = 3'b100, SRC_LOW_POWER_RC_OSCILLATOR = 3'b101, SRC_FRC_16 = 3'b110, SRC_FRC_N = 3'b111
  } source_t;
endpackage

/* verif/tb_osc_ctrl.sv */
// Self-checking bench for the oscillator select and divider registers
// Assumes the design's own assertions are enabled alongside
module tb_osc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import osc_ctrl_pkg::*;
  logic clk = 0, reset = 1, wr = 0, rd = 0, unlocked = 0, switch_enabled = 1;
  logic pll_locked = 0, monitor_fail = 0, new_clock_tick = 0, interrupt = 0;
  logic [1:0] addr = 0, switch_monitor_config = 0;
  logic [15:0] wdata = 0, rdata, d;
  logic [2:0] config_source = 3'h2, current_source, requested_source;
  logic [2:0] processor_clock_reduction, fast_rc_postscaler;
  logic pin_select_lock, secondary_osc_enable, switch_busy, reduction_active, rd_seen = 0;
  logic [1:0] pll_postscaler;
  logic [4:0] pll_prescaler;
  logic [8:0] pll_feedback_multiplier;
  logic [5:0] fast_rc_trim;
  logic [15:0] exp_q[$];
  int errors = 0, check_count = 0, cycles = 0;
  osc_ctrl i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .unlocked(unlocked), .config_source(config_source),
    .switch_monitor_config(switch_monitor_config), .switch_enabled(switch_enabled),
    .pll_locked(pll_locked), .monitor_fail(monitor_fail), .new_clock_tick(new_clock_tick),
    .interrupt(interrupt), .current_source(current_source),
    .requested_source(requested_source), .pin_select_lock(pin_select_lock),
    .secondary_osc_enable(secondary_osc_enable), .switch_busy(switch_busy),
    .reduction_active(reduction_active), .processor_clock_reduction(processor_clock_reduction),
    .fast_rc_postscaler(fast_rc_postscaler), .pll_postscaler(pll_postscaler),
    .pll_prescaler(pll_prescaler), .pll_feedback_multiplier(pll_feedback_multiplier),
    .fast_rc_trim(fast_rc_trim));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_read(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected read at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_port(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected port at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    #1;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) new_clock_tick <= 1;
      @(posedge clk) new_clock_tick <= 0;
    end
  endtask
  task automatic irq;
    @(posedge clk) interrupt <= 1;
    @(posedge clk) interrupt <= 0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) cmp_read(rdata, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      errors++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(70));
    repeat (16) @(posedge clk);
    reset <= 0;
    repeat (3) @(posedge clk);
    reg_rd(ADDR_OSC_CONTROL, 16'h2200);
    reg_rd(ADDR_CLOCK_DIVISOR, 16'h3040);
    reg_rd(ADDR_PLL_FEEDBACK, 16'h0030);
    reg_rd(ADDR_FRC_TUNING, 16'h0000);
    pll_locked <= 1;
    reg_rd(ADDR_OSC_CONTROL, 16'h2220);
    reg_wr(ADDR_OSC_CONTROL, 16'h00C3);
    reg_rd(ADDR_OSC_CONTROL, 16'h2220);
    $display("reset and lockout done");
    unlocked <= 1;
    reg_wr(ADDR_OSC_CONTROL, 16'h0043);
    reg_rd(ADDR_OSC_CONTROL, 16'h2063);
    settle;
    cmp_port({14'h0, pin_select_lock, secondary_osc_enable}, 16'h0003);
    ticks(9);
    settle;
    cmp_port({15'h0, switch_busy}, 16'h0001);
    ticks(3);
    settle;
    cmp_port({12'h0, switch_busy, current_source}, 16'h0000);
    reg_rd(ADDR_OSC_CONTROL, 16'h0062);
    reg_wr(ADDR_OSC_CONTROL, 16'h0043);
    repeat (3) @(posedge clk);
    cmp_port({15'h0, switch_busy}, 16'h0000);
    $display("switching done");
    @(posedge clk) monitor_fail <= 1;
    @(posedge clk) monitor_fail <= 0;
    reg_rd(ADDR_OSC_CONTROL, 16'h006A);
    reg_wr(ADDR_OSC_CONTROL, 16'h004A);
    reg_rd(ADDR_OSC_CONTROL, 16'h006A);
    reg_wr(ADDR_OSC_CONTROL, 16'h0042);
    reg_rd(ADDR_OSC_CONTROL, 16'h0062);
    switch_monitor_config <= MONITOR_SW_ONLY;
    reg_wr(ADDR_OSC_CONTROL, 16'h00C2);
    reg_wr(ADDR_OSC_CONTROL, 16'h02C3);
    ticks(12);
    settle;
    cmp_port({12'h0, switch_busy, current_source}, 16'h0000);
    switch_monitor_config <= 2'h0;
    switch_enabled <= 0;
    reg_wr(ADDR_OSC_CONTROL, 16'h02C3);
    ticks(12);
    settle;
    cmp_port({12'h0, switch_busy, current_source}, {13'h0, config_source});
    $display("fail flag and locks done");
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      reg_wr(ADDR_CLOCK_DIVISOR, d & 16'h7FFF);
      reg_rd(ADDR_CLOCK_DIVISOR, d & 16'h7FDF);
      settle;
      cmp_port({processor_clock_reduction, fast_rc_postscaler, pll_postscaler, 3'h0,
        pll_prescaler}, {d[14:12], d[10:6], 3'h0, d[4:0]});
      reg_wr(ADDR_PLL_FEEDBACK, d);
      reg_rd(ADDR_PLL_FEEDBACK, d & 16'h01FF);
      settle;
      cmp_port({7'h0, pll_feedback_multiplier}, d & 16'h01FF);
      reg_wr(ADDR_FRC_TUNING, d);
      reg_rd(ADDR_FRC_TUNING, d & 16'h003F);
      settle;
      cmp_port({10'h0, fast_rc_trim}, d & 16'h003F);
    end
    reg_wr(ADDR_CLOCK_DIVISOR, 16'h8B00);
    settle;
    cmp_port({15'h0, reduction_active}, 16'h0001);
    irq;
    @(posedge clk);
    settle;
    cmp_port({15'h0, reduction_active}, 16'h0000);
    reg_rd(ADDR_CLOCK_DIVISOR, 16'h8300);
    reg_wr(ADDR_CLOCK_DIVISOR, 16'h0B00);
    irq;
    reg_rd(ADDR_CLOCK_DIVISOR, 16'h0B00);
    repeat (3) @(posedge clk);
    $display("divisors and recovery done");
    stop_test;
  end
endmodule // tb_osc_ctrl
